// ### logic/aphp_defs.svh
`ifndef APHP_DEFS_SVH
`define APHP_DEFS_SVH

// Clock rate and documented times
`define APHP_CLK_MHZ        100
`define APHP_RESET_US       10
`define APHP_STARTUP_MS     1
`define APHP_RESET_CYC      ((`APHP_RESET_US * `APHP_CLK_MHZ))
`define APHP_STARTUP_CYC    ((`APHP_STARTUP_MS * 1000 * `APHP_CLK_MHZ))
`define APHP_SETUP_NS       15
`define APHP_STROBE_NS      15
`define APHP_RECOV_NS       10
`define APHP_READ_NS        30
`define APHP_CLK_NS         10
`define APHP_SETUP_CYC      ((`APHP_SETUP_NS + `APHP_CLK_NS - 1) / `APHP_CLK_NS)
`define APHP_STROBE_CYC     ((`APHP_STROBE_NS + `APHP_CLK_NS - 1) / `APHP_CLK_NS)
`define APHP_RECOV_CYC      ((`APHP_RECOV_NS + `APHP_CLK_NS - 1) / `APHP_CLK_NS)
`define APHP_READ_CYC       ((`APHP_READ_NS + `APHP_CLK_NS - 1) / `APHP_CLK_NS)
// Mode strap encodings, bit3 down to bit0
`define APHP_STRAP_8BIT     4'h8
`define APHP_STRAP_16BIT    4'h7
`define APHP_ADDR_W         14

`endif

// ### logic/aphp_pkg.sv
package aphp_pkg;
    typedef enum logic {
        APHP_W8,
        APHP_W16
    } aphp_width_t;
    typedef enum logic [2:0] {
        APHP_RST,
        APHP_BOOT,
        APHP_IDLE,
        APHP_SETUP,
        APHP_STROBE,
        APHP_RECOV
    } aphp_state_t;
endpackage

// ### logic/aphp_timer.sv
`timescale 1ns/1ps
module aphp_timer #(
    parameter int W = 17
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    output logic              done
);
    logic [W-1:0] cnt_r;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (load) begin
            cnt_r <= count;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    // Done ignores load, so a caller may reload on done without a combinational loop
    assign done = (cnt_r == '0);
endmodule // aphp_timer

// ### logic/aphp_host.sv
`timescale 1ns/1ps
`include "aphp_defs.svh"
// Operation
// - Host selects parallel port through the four mode straps.
// - Host takes interrupt line into an input software can test.
// - 8-bit mode uses byte address lines 0 to 13.
// - 16-bit mode uses lines 1 to 13 and 16-bit data.
// - 8-bit write strobe active low; pure strobe or read-not-write.
// - 8-bit mode straps: low three low, top strap high.
// - 16-bit mode straps: low three high, top strap low.
module aphp_host #(
    parameter int RESET_CYC   = `APHP_RESET_CYC,
    parameter int STARTUP_CYC = `APHP_STARTUP_CYC,
    parameter bit WIDE        = 1'b0
) (
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    input  wire logic                    req_valid,
    input  wire logic                    req_write,
    input  wire logic [`APHP_ADDR_W-1:0] req_addr,
    input  wire logic [15:0]             req_wdata,
    input  wire logic [1:0]              req_be,
    output logic                         req_ready,
    output logic                         rsp_valid,
    output logic [15:0]                  rsp_rdata,
    output logic                         irq_pending,
    output aphp_pkg::aphp_width_t        bus_width,
    output logic                         module_reset_n,
    output logic [3:0]                   mode_strap_o,
    output logic [3:0]                   mode_strap_oe,
    output logic                         cs_n,
    output logic                         oe_n,
    output logic                         lower_byte_write_n,
    output logic                         upper_byte_write_n,
    output logic [`APHP_ADDR_W-1:0]      addr,
    output logic [15:0]                  data_o,
    output logic [15:0]                  data_oe,
    input  wire logic [15:0]             data_i,
    input  wire logic                    irq_n
);
    import aphp_pkg::*;

    localparam int TW = 17;

    aphp_state_t      state_r, state_nxt;
    logic             wr_r, rd_hit;
    logic [1:0]       be_r;
    logic [15:0]      wdata_r, rdata_r;
    logic [`APHP_ADDR_W-1:0] addr_r;
    logic             rsp_r, irq_r, reset_n_r;
    logic             tload;
    logic [TW-1:0]    tcount;
    logic             tdone;
    logic             strap_drive;
    logic [3:0]       strap_val;
    logic             started_r, rst_kick;

    aphp_timer #(.W(TW)) u_timer (
        .sys_clk (sys_clk),
        .rst     (rst),
        .load    (tload),
        .count   (tcount),
        .done    (tdone)
    );

    // Straps held while the module is in reset and into startup
    assign strap_val   = WIDE ? `APHP_STRAP_16BIT : `APHP_STRAP_8BIT;
    assign strap_drive = (state_r == APHP_RST) || (state_r == APHP_BOOT);
    assign mode_strap_o  = strap_val;
    assign mode_strap_oe = strap_drive ? 4'hF : 4'h0;
    assign bus_width     = WIDE ? APHP_W16 : APHP_W8;

    always_comb begin
        state_nxt = state_r;
        tload     = 1'b0;
        tcount    = '0;
        unique case (state_r)
            APHP_RST: begin
                // The module reset pulse is counted out before the startup wait begins
                if (rst_kick) begin
                    tload     = 1'b1;
                    tcount    = TW'(RESET_CYC);
                end else if (tdone) begin
                    state_nxt = APHP_BOOT;
                    tload     = 1'b1;
                    tcount    = TW'(STARTUP_CYC);
                end
            end
            APHP_BOOT: begin
                if (tdone) begin
                    state_nxt = APHP_IDLE;
                end
            end
            APHP_IDLE: begin
                if (req_valid) begin
                    state_nxt = APHP_SETUP;
                    tload     = 1'b1;
                    tcount    = TW'(`APHP_SETUP_CYC);
                end
            end
            APHP_SETUP: begin
                if (tdone) begin
                    state_nxt = APHP_STROBE;
                    tload     = 1'b1;
                    tcount    = wr_r ? TW'(`APHP_STROBE_CYC) : TW'(`APHP_READ_CYC);
                end
            end
            APHP_STROBE: begin
                if (tdone) begin
                    state_nxt = APHP_RECOV;
                    tload     = 1'b1;
                    tcount    = TW'(`APHP_RECOV_CYC);
                end
            end
            APHP_RECOV: begin
                if (tdone) begin
                    state_nxt = APHP_IDLE;
                end
            end
            default: state_nxt = APHP_RST;
        endcase
    end

    // Reset pulse is timed from the first cycle after rst
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= APHP_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            started_r <= 1'b0;
        end else begin
            started_r <= 1'b1;
        end
    end
    // Kick the reset timer once right after release
    assign rst_kick = !started_r;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_r    <= 1'b0;
            be_r    <= 2'b00;
            wdata_r <= 16'h0000;
            addr_r  <= '1;
        end else if (state_r == APHP_IDLE && req_valid) begin
            wr_r    <= req_write;
            be_r    <= WIDE ? req_be : 2'b01;
            wdata_r <= req_wdata;
            // Word mode ignores line 0; all-ones would also ack the device interrupt
            addr_r  <= WIDE ? {req_addr[`APHP_ADDR_W-1:1], 1'b0} : req_addr;
        end
    end

    assign rd_hit = (state_r == APHP_STROBE) && !wr_r && tdone;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_r   <= 16'h0000;
            rsp_r     <= 1'b0;
            reset_n_r <= 1'b0;
            irq_r     <= 1'b0;
        end else begin
            rsp_r     <= (state_r == APHP_RECOV) && tdone;
            reset_n_r <= (state_r != APHP_RST) || (tdone && started_r);
            irq_r     <= (state_r != APHP_RST) && (state_r != APHP_BOOT) && !irq_n;
            if (rd_hit) begin
                rdata_r <= WIDE ? data_i : {8'h00, data_i[7:0]};
            end
        end
    end


    assign module_reset_n     = reset_n_r;
    assign req_ready          = (state_r == APHP_IDLE);
    assign rsp_valid          = rsp_r;
    assign rsp_rdata          = rdata_r;
    assign irq_pending        = irq_r;
    assign addr               = addr_r;
    assign cs_n               = !((state_r == APHP_SETUP) || (state_r == APHP_STROBE));
    // Output enable only asserted for reads so the bus never fights
    assign oe_n               = !((state_r == APHP_SETUP || state_r == APHP_STROBE) && !wr_r);
    assign lower_byte_write_n = !((state_r == APHP_STROBE) && wr_r && be_r[0]);
    assign upper_byte_write_n = !((state_r == APHP_STROBE) && wr_r && be_r[1] && WIDE);
    assign data_o             = wdata_r;
    // Upper lines are device indicator outputs in byte mode
    assign data_oe = (wr_r && (state_r == APHP_SETUP || state_r == APHP_STROBE || state_r == APHP_RECOV))
                     ? (WIDE ? 16'hFFFF : 16'h00FF) : 16'h0000;

    cov_write_c: cover property (@(posedge sys_clk) !lower_byte_write_n);
    cov_read_c:  cover property (@(posedge sys_clk) rsp_valid);
    cov_irq_c:   cover property (@(posedge sys_clk) irq_pending);

    no_fight_a: assert property (@(posedge sys_clk) disable iff (rst)
        !oe_n |-> data_oe == 16'h0000) else $error("data driven during read");
    cs_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
        cs_n |-> oe_n && lower_byte_write_n && upper_byte_write_n) else $error("strobe without select");
    strap_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        !module_reset_n |-> mode_strap_oe == 4'hF) else $error("straps not held in reset");
    strap_val_a: assert property (@(posedge sys_clk) disable iff (rst)
        mode_strap_oe != 4'h0 |-> mode_strap_o == {!WIDE, {3{WIDE}}}) else $error("bad strap code");
    byte_upper_a: assert property (@(posedge sys_clk) disable iff (rst)
        !WIDE |-> data_oe[15:8] == 8'h00 && upper_byte_write_n) else $error("upper lane driven");
    wr_data_a: assert property (@(posedge sys_clk) disable iff (rst)
        !lower_byte_write_n |-> data_oe[0] && !cs_n) else $error("write without data");
    wr_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(lower_byte_write_n) |-> !lower_byte_write_n[*2]) else $error("write pulse short");
    word_addr_a: assert property (@(posedge sys_clk) disable iff (rst)
        WIDE && !cs_n |-> !addr[0]) else $error("line 0 used in word mode");
    irq_boot_a: assert property (@(posedge sys_clk) disable iff (rst)
        !module_reset_n |=> !irq_pending) else $error("irq during reset");
endmodule // aphp_host

// ### verif/aphp_dev_model.sv
`timescale 1ns/1ps
module aphp_dev_model (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic [3:0]  strap,
    input  wire logic        cs_n,
    input  wire logic        oe_n,
    input  wire logic        wl_n,
    input  wire logic        wh_n,
    input  wire logic [13:0] addr,
    input  wire logic [15:0] host_d,
    input  wire logic [15:0] host_oe,
    input  wire logic        irq_req,
    output logic [15:0]      bus_d,
    output logic             irq_n,
    output logic [3:0]       strap_q
);
    logic [15:0] mem [0:8191];
    logic [15:0] flt;
    logic [15:0] rd;
    logic        wide;
    logic        drv;
    logic        irq_r;
    initial begin
        for (int i = 0; i < 8192; i++) mem[i] = 16'h0000;
        flt = 16'h3C5A;
        strap_q = 4'h0;
    end
    always @(posedge reset_n) strap_q <= strap;
    assign wide = (strap_q == 4'h7);
    assign drv  = !cs_n && !oe_n && wl_n && wh_n;
    // Upper pins carry indicator levels in byte mode, never memory data
    assign rd   = wide ? mem[addr[13:1]] : {8'hA5, addr[0] ? mem[addr[13:1]][15:8] : mem[addr[13:1]][7:0]};
    // Undriven lines have no pull, so they show a pattern that never repeats the last value
    assign bus_d = (host_d & host_oe) | (~host_oe & (drv ? rd : flt));
    assign irq_n = !irq_r;
    always @(posedge sys_clk) begin
        flt <= ~flt;
        if (!cs_n && !wl_n) begin
            if (wide || !addr[0]) mem[addr[13:1]][7:0] <= host_d[7:0];
            else mem[addr[13:1]][15:8] <= host_d[7:0];
        end
        if (!cs_n && !wh_n && wide) mem[addr[13:1]][15:8] <= host_d[15:8];
        if (!reset_n) irq_r <= 1'b0;
        else if (!cs_n && (&addr[13:1]) && (wide || addr[0])) irq_r <= 1'b0;
        else if (irq_req) irq_r <= 1'b1;
    end
endmodule // aphp_dev_model

// ### verif/tb_aphp_host.sv
`timescale 1ns/1ps
module tb_aphp_host;
    import aphp_pkg::*;
    logic sys_clk, rst, req_valid, req_write, req_ready, rsp_valid, irq_pending, module_reset_n;
    logic cs_n, oe_n, wl_n, wh_n, irq_n, irq_req;
    logic [13:0] req_addr, addr;
    logic [15:0] req_wdata, rsp_rdata, data_o, data_oe, data_i;
    logic [1:0] req_be;
    logic [3:0] strap_o, strap_oe, strap_q;
    aphp_width_t bus_width;
    logic [16:0] exp_q[$];
    logic [15:0] ref_m[int];
    logic [13:0] al[8];
    int failures = 0;
    int num_checks = 0;
    int n;
    // Byte-mode copy of the host sees the same requests, so both run in lockstep
    logic rsp_valid_b, irq_pending_b, module_reset_n_b, cs_n_b, oe_n_b, wl_n_b, wh_n_b, irq_n_b;
    logic [13:0] addr_b;
    logic [15:0] rsp_rdata_b, data_o_b, data_oe_b, data_i_b;
    logic [3:0] strap_o_b, strap_oe_b, strap_q_b;
    aphp_width_t bus_width_b;
    logic [16:0] exp_b_q[$];
    logic [7:0] ref_b[int];
    aphp_host #(.RESET_CYC(4), .STARTUP_CYC(20), .WIDE(1'b1)) DUT (.sys_clk(sys_clk), .rst(rst),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_be(req_be), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .irq_pending(irq_pending), .bus_width(bus_width), .module_reset_n(module_reset_n),
        .mode_strap_o(strap_o), .mode_strap_oe(strap_oe), .cs_n(cs_n), .oe_n(oe_n),
        .lower_byte_write_n(wl_n), .upper_byte_write_n(wh_n), .addr(addr), .data_o(data_o),
        .data_oe(data_oe), .data_i(data_i), .irq_n(irq_n));
    // Only the top strap has a pull-up when the host lets go
    aphp_dev_model u_dev (.sys_clk(sys_clk), .reset_n(module_reset_n),
        .strap((strap_o & strap_oe) | (~strap_oe & 4'h8)), .cs_n(cs_n), .oe_n(oe_n), .wl_n(wl_n),
        .wh_n(wh_n), .addr(addr), .host_d(data_o), .host_oe(data_oe), .irq_req(irq_req),
        .bus_d(data_i), .irq_n(irq_n), .strap_q(strap_q));
    aphp_host #(.RESET_CYC(4), .STARTUP_CYC(20), .WIDE(1'b0)) DUT_BYTE (.sys_clk(sys_clk), .rst(rst),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_be(req_be), .req_ready(), .rsp_valid(rsp_valid_b), .rsp_rdata(rsp_rdata_b),
        .irq_pending(irq_pending_b), .bus_width(bus_width_b), .module_reset_n(module_reset_n_b),
        .mode_strap_o(strap_o_b), .mode_strap_oe(strap_oe_b), .cs_n(cs_n_b), .oe_n(oe_n_b),
        .lower_byte_write_n(wl_n_b), .upper_byte_write_n(wh_n_b), .addr(addr_b), .data_o(data_o_b),
        .data_oe(data_oe_b), .data_i(data_i_b), .irq_n(irq_n_b));
    aphp_dev_model u_dev_b (.sys_clk(sys_clk), .reset_n(module_reset_n_b),
        .strap((strap_o_b & strap_oe_b) | (~strap_oe_b & 4'h8)), .cs_n(cs_n_b), .oe_n(oe_n_b), .wl_n(wl_n_b),
        .wh_n(wh_n_b), .addr(addr_b), .host_d(data_o_b), .host_oe(data_oe_b), .irq_req(irq_req),
        .bus_d(data_i_b), .irq_n(irq_n_b), .strap_q(strap_q_b));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Expected read data comes from a shadow of every write, merged by byte enable
    task automatic xfer(input logic wr, input logic [13:0] a, input logic [15:0] d, input logic [1:0] be);
        logic [15:0] old;
        logic [7:0] old_b;
        int k;
        old = ref_m.exists(int'(a[13:1])) ? ref_m[int'(a[13:1])] : 16'h0000;
        if (wr) ref_m[int'(a[13:1])] = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
        exp_q.push_back({!wr, old});
        // Byte mode ignores the enables and stores the low byte at the full address
        old_b = ref_b.exists(int'(a)) ? ref_b[int'(a)] : 8'h00;
        if (wr) ref_b[int'(a)] = d[7:0];
        exp_b_q.push_back({!wr, 8'h00, old_b});
        @(posedge sys_clk);
        #1;
        {req_valid, req_write, req_addr, req_wdata, req_be} = {1'b1, wr, a, d, be};
        k = 0;
        while (req_ready !== 1'b1 && k < 100) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        @(posedge sys_clk);
        #1;
        req_valid = 1'b0;
    endtask
    always @(posedge sys_clk) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) check("response count", 16'h0000, 16'h0001);
            else if (exp_q[0][16]) check("read data", exp_q[0][15:0], rsp_rdata);
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
        if (rsp_valid_b === 1'b1) begin
            if (exp_b_q.size() == 0) check("byte response count", 16'h0000, 16'h0001);
            else if (exp_b_q[0][16]) check("byte read data", exp_b_q[0][15:0], rsp_rdata_b);
            if (exp_b_q.size() != 0) void'(exp_b_q.pop_front());
        end
    end
    initial begin
        #100000;
        failures++;
        $display("CHECK FAILED watchdog expected done seen timeout");
        close_out();
    end
    initial begin
        {req_valid, req_write, req_addr, req_wdata, req_be, irq_req} = '0;
        rst = 1'b1;
        void'($urandom(32'h544347c3));
        repeat (12) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        // The module reset must stay low for at least the reset count after release
        for (n = 0; n < 50 && module_reset_n !== 1'b1; n++) @(posedge sys_clk);
        check("reset width", 16'h0001, {15'h0, (n >= 4)});
        for (n = 0; n < 500 && req_ready !== 1'b1; n++) @(posedge sys_clk);
        check("strap", 16'h0007, {12'h000, strap_q});
        check("byte strap", 16'h0008, {12'h000, strap_q_b});
        check("bus width", 16'h0001, {15'h0, bus_width});
        check("byte bus width", 16'h0000, {15'h0, bus_width_b});
        check("irq idle", 16'h0000, {15'h0, irq_pending});
        check("byte irq idle", 16'h0000, {15'h0, irq_pending_b});
        for (int i = 0; i < 8; i++) begin
            al[i] = 14'($urandom) & 14'h3FF0;
            xfer(1'b1, al[i], 16'($urandom), 2'b11);
        end
        for (int i = 0; i < 8; i++) xfer(1'b0, al[i], 16'h0000, 2'b11);
        xfer(1'b1, 14'h0021, 16'h1234, 2'b11);
        xfer(1'b1, 14'h0020, 16'hAB77, 2'b10);
        xfer(1'b0, 14'h0020, 16'h0000, 2'b11);
        xfer(1'b1, 14'h0020, 16'h66CD, 2'b01);
        xfer(1'b0, 14'h0020, 16'h0000, 2'b11);
        irq_req = 1'b1;
        @(posedge sys_clk);
        #1;
        irq_req = 1'b0;
        for (n = 0; n < 20 && (irq_pending !== 1'b1 || irq_pending_b !== 1'b1); n++) @(posedge sys_clk);
        check("irq raised", 16'h0001, {15'h0, irq_pending});
        check("byte irq raised", 16'h0001, {15'h0, irq_pending_b});
        xfer(1'b0, 14'h3FFF, 16'h0000, 2'b11);
        for (n = 0; n < 20 && (irq_pending !== 1'b0 || irq_pending_b !== 1'b0); n++) @(posedge sys_clk);
        check("irq cleared", 16'h0000, {15'h0, irq_pending});
        check("byte irq cleared", 16'h0000, {15'h0, irq_pending_b});
        for (n = 0; n < 50 && (exp_q.size() != 0 || exp_b_q.size() != 0); n++) @(posedge sys_clk);
        check("pending responses", 16'h0000, 16'(exp_q.size() + exp_b_q.size()));
        close_out();
    end
endmodule // tb_aphp_host
